// File: hdl/pigc_partition_ctrl.sv
// Partition ID generation control: registers, request tagging and access trap checks.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Writable enable only at highest level; copies read-only
// - Enable set: normal IDs; clear: default IDs
// - Reset clears the generation enable
// - Secure override writable only when capability present
// - Secure override gives default group and ID
// - Secure override affects only Secure-state requests
// - Secure override bit left unreset
// - Disabled or overridden Secure: ID 0, group 0
// - Lower-level trap sends EL1/EL2 accesses to EL3
// - Lower-level trap beats EL2 trap controls
// - Nested virtualisation routes EL1 EL2-register accesses to EL2
// - Enhanced nested virtualisation turns accesses into memory
// - No Secure IDs: space override reads one
// - Writable space override sets Secure tag
// - Writable space override resets to 0
// - No space capability: override reads zero
// - Reset sets the lower-level trap
// - EL2 traps unreset with EL3, else set
// - No EL3: EL3 register undefined, trap off
// - No EL2: EL2 registers zero, traps inactive
// - Non-secure-only EL2: access and Secure trap rules
// - Secure EL2 off behaves as Non-secure-only EL2
module pigc_partition_ctrl #(
  parameter bit HAS_EL3        = 1'b1,
  parameter bit HAS_EL2        = 1'b1,
  parameter bit HAS_SECURE_EL2 = 1'b1,
  parameter bit SDEF_PRESENT   = 1'b1,
  parameter bit SPACE_PRESENT  = 1'b1,
  parameter bit SECURE_PIDS    = 1'b1,
  parameter int PID_W          = 16,
  parameter int GRP_W          = 8
) (
  input  wire logic             clk_in,                // 20 MHz clock
  input  wire logic             reset_in,              // Warm or cold reset
  input  wire logic [4:0]       avs_address_in,        // Byte address
  input  wire logic             avs_read_in,           // Read request
  input  wire logic             avs_write_in,          // Write request
  input  wire logic [31:0]      avs_writedata_in,      // Write data
  input  wire logic [3:0]       avs_byteenable_in,     // Byte lanes
  output logic      [31:0]      avs_readdata_out,      // Read data
  output logic                  avs_waitrequest_out,   // Stall
  input  wire logic             secure_el2_enable_in,  // Secure EL2 enabled
  input  wire logic             nested_virt_in,        // nested_virtualisation
  input  wire logic             enh_nested_virt_in,    // enhanced_nested_virtualisation
  input  wire logic             host_mode_in,          // host_mode
  input  wire logic             req_valid_in,          // Outgoing request
  input  wire logic             req_secure_in,         // Request from Secure state
  output logic                  req_valid_out,         // Tagged request
  output logic      [PID_W-1:0] partition_id_out,      // partition_id
  output logic      [GRP_W-1:0] monitor_group_out,     // monitor_group
  output logic                  security_space_tag_out,// security_space_tag
  input  wire logic             acc_valid_in,          // Register access to check
  input  wire logic [1:0]       acc_el_in,             // Exception level of access
  input  wire logic             acc_secure_in,         // Access from Secure state
  input  wire logic [2:0]       acc_reg_in,            // Register selected
  output logic                  acc_done_out,          // Check result valid
  output logic      [2:0]       acc_result_out         // Check outcome
);

  typedef struct packed {
    logic             wait_q;
    logic [31:0]      rdata;
    logic             id_gen_enable;
    logic             secure_default_override;
    logic             secure_space_override;
    logic             lower_level_trap;
    logic             el1_register_trap;
    logic             el0_register_trap;
    logic             id_register_read_trap;
    logic             guest_app_partition_lock;
    logic             el1_virtual_map_enable;
    logic             el0_virtual_map_enable;
    logic [PID_W-1:0] el1_pid;
    logic [GRP_W-1:0] el1_grp;
    logic             rq_valid;
    logic [PID_W-1:0] rq_pid;
    logic [GRP_W-1:0] rq_grp;
    logic             rq_tag;
    logic             ac_done;
    logic [2:0]       ac_result;
    logic [2:0]       last_result;
  } pigc_state_s;

  pigc_state_s state_r;
  pigc_state_s state_nxt;

  // Merge write data into an old word under byte enables
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  // EL2 acts in the given security state
  function automatic logic el2_active(input logic secure);
    return HAS_EL2 && (!secure || (HAS_SECURE_EL2 && secure_el2_enable_in));
  endfunction

  // Effective control bits as seen by generation and checks
  logic sdef_eff;
  logic space_eff;
  logic trap_low_eff;
  always_comb begin
    sdef_eff     = SDEF_PRESENT && HAS_EL3 && state_r.secure_default_override;
    if (!SPACE_PRESENT || !HAS_EL3) begin
      space_eff = 1'b0;
    end else if (!SECURE_PIDS) begin
      space_eff = 1'b1;
    end else begin
      space_eff = state_r.secure_space_override;
    end
    trap_low_eff = HAS_EL3 && state_r.lower_level_trap;
  end

  // Register read views
  logic [31:0] el3_view;
  logic [31:0] el2_view;
  logic [31:0] hcr_view;
  logic [31:0] el1_view;
  logic [31:0] idr_view;
  logic [31:0] rd_word;
  always_comb begin
    el3_view = 32'h0000_0000;
    el2_view = 32'h0000_0000;
    hcr_view = 32'h0000_0000;
    el1_view = 32'h0000_0000;
    idr_view = 32'h0000_0000;
    if (HAS_EL3) begin
      el3_view[pigc_pkg::EL3_EN_BIT]    = state_r.id_gen_enable;
      el3_view[pigc_pkg::EL3_SDEF_BIT]  = sdef_eff;
      el3_view[pigc_pkg::EL3_SPACE_BIT] = space_eff;
      el3_view[pigc_pkg::EL3_TRAP_BIT]  = state_r.lower_level_trap;
    end
    if (HAS_EL2) begin
      el2_view[pigc_pkg::EL2_EN_BIT]   = state_r.id_gen_enable;
      el2_view[pigc_pkg::EL2_T1_BIT]   = state_r.el1_register_trap;
      el2_view[pigc_pkg::EL2_T0_BIT]   = state_r.el0_register_trap;
      hcr_view[pigc_pkg::HCR_IDT_BIT]  = state_r.id_register_read_trap;
      hcr_view[pigc_pkg::HCR_LOCK_BIT] = state_r.guest_app_partition_lock;
      hcr_view[pigc_pkg::HCR_VM1_BIT]  = state_r.el1_virtual_map_enable;
      hcr_view[pigc_pkg::HCR_VM0_BIT]  = state_r.el0_virtual_map_enable;
    end
    el1_view[pigc_pkg::EL1_PID_LSB +: PID_W] = state_r.el1_pid;
    el1_view[pigc_pkg::EL1_GRP_LSB +: GRP_W] = state_r.el1_grp;
    el1_view[pigc_pkg::EL1_EN_BIT]           = state_r.id_gen_enable;
    idr_view[pigc_pkg::IDR_SDEF_BIT]  = SDEF_PRESENT;
    idr_view[pigc_pkg::IDR_SPACE_BIT] = SPACE_PRESENT;
    idr_view[pigc_pkg::IDR_EL3_BIT]   = HAS_EL3;
    idr_view[pigc_pkg::IDR_EL2_BIT]   = HAS_EL2;
    idr_view[pigc_pkg::IDR_SPID_BIT]  = SECURE_PIDS;
    case (avs_address_in)
      pigc_pkg::ADDR_EL3:  rd_word = el3_view;
      pigc_pkg::ADDR_EL2:  rd_word = el2_view;
      pigc_pkg::ADDR_HCR:  rd_word = hcr_view;
      pigc_pkg::ADDR_EL1:  rd_word = el1_view;
      pigc_pkg::ADDR_IDR:  rd_word = idr_view;
      pigc_pkg::ADDR_STAT: rd_word = {29'h0000_0000, state_r.last_result};
      default:             rd_word = 32'h0000_0000;
    endcase
  end

  // Access check for one system-register access
  function automatic logic [2:0] check_access(input logic [1:0] el,
                                              input logic       sec,
                                              input logic [2:0] rsel);
    logic             el2_on;
    logic [2:0]       res;
    pigc_pkg::pigc_reg_e r;
    el2_on = el2_active(sec);
    r      = pigc_pkg::pigc_reg_e'(rsel);
    res    = pigc_pkg::ACC_UNDEF;
    case (r)
      pigc_pkg::REG_EL3: begin
        if (HAS_EL3 && el == 2'd3) begin
          res = pigc_pkg::ACC_ALLOW;
        end
      end
      pigc_pkg::REG_EL2, pigc_pkg::REG_HCR, pigc_pkg::REG_VMAP, pigc_pkg::REG_ALIAS: begin
        if (el == 2'd3) begin
          res = (r == pigc_pkg::REG_ALIAS && !HAS_EL2) ? pigc_pkg::ACC_UNDEF
                                                     : pigc_pkg::ACC_ALLOW;
        end else if (el == 2'd2 && el2_on) begin
          if (r == pigc_pkg::REG_ALIAS && !host_mode_in) begin
            res = pigc_pkg::ACC_UNDEF;
          end else if (trap_low_eff) begin
            res = pigc_pkg::ACC_TRAP_EL3;
          end else begin
            res = pigc_pkg::ACC_ALLOW;
          end
        end else if (el == 2'd1 && el2_on && nested_virt_in) begin
          if (enh_nested_virt_in) begin
            res = pigc_pkg::ACC_MEMORY;
          end else if (trap_low_eff) begin
            res = pigc_pkg::ACC_TRAP_EL3;
          end else begin
            res = pigc_pkg::ACC_TRAP_EL2;
          end
        end
      end
      pigc_pkg::REG_EL1, pigc_pkg::REG_IDR: begin
        if (el == 2'd3) begin
          res = pigc_pkg::ACC_ALLOW;
        end else if (el == 2'd2 || el == 2'd1) begin
          if (trap_low_eff) begin
            res = pigc_pkg::ACC_TRAP_EL3;
          end else if (el == 2'd1 && el2_on &&
                       ((r == pigc_pkg::REG_EL1 && state_r.el1_register_trap) ||
                        (r == pigc_pkg::REG_IDR && state_r.id_register_read_trap))) begin
            res = pigc_pkg::ACC_TRAP_EL2;
          end else begin
            res = pigc_pkg::ACC_ALLOW;
          end
        end
      end
      default: res = pigc_pkg::ACC_UNDEF;
    endcase
    return res;
  endfunction

  // Next state
  logic        bus_req;
  logic        bus_take;
  logic [31:0] wword;
  always_comb begin
    state_nxt = state_r;
    bus_req   = avs_read_in || avs_write_in;
    bus_take  = bus_req && !state_r.wait_q;
    wword     = merge_bytes(rd_word, avs_writedata_in, avs_byteenable_in);

    // One wait cycle, then the access completes
    if (bus_take) begin
      state_nxt.wait_q = 1'b1;
    end else if (bus_req) begin
      state_nxt.wait_q = 1'b0;
      state_nxt.rdata  = rd_word;
    end else begin
      state_nxt.wait_q = 1'b1;
    end

    if (bus_take && avs_write_in) begin
      case (avs_address_in)
        pigc_pkg::ADDR_EL3: begin
          if (HAS_EL3) begin
            state_nxt.id_gen_enable    = wword[pigc_pkg::EL3_EN_BIT];
            state_nxt.lower_level_trap = wword[pigc_pkg::EL3_TRAP_BIT];
            if (SDEF_PRESENT) begin
              state_nxt.secure_default_override = wword[pigc_pkg::EL3_SDEF_BIT];
            end
            if (SPACE_PRESENT && SECURE_PIDS) begin
              state_nxt.secure_space_override = wword[pigc_pkg::EL3_SPACE_BIT];
            end
          end
        end
        pigc_pkg::ADDR_EL2: begin
          if (HAS_EL2) begin
            if (!HAS_EL3) begin
              state_nxt.id_gen_enable = wword[pigc_pkg::EL2_EN_BIT];
            end
            state_nxt.el1_register_trap = wword[pigc_pkg::EL2_T1_BIT];
            state_nxt.el0_register_trap = wword[pigc_pkg::EL2_T0_BIT];
          end
        end
        pigc_pkg::ADDR_HCR: begin
          if (HAS_EL2) begin
            state_nxt.id_register_read_trap    = wword[pigc_pkg::HCR_IDT_BIT];
            state_nxt.guest_app_partition_lock = wword[pigc_pkg::HCR_LOCK_BIT];
            state_nxt.el1_virtual_map_enable   = wword[pigc_pkg::HCR_VM1_BIT];
            state_nxt.el0_virtual_map_enable   = wword[pigc_pkg::HCR_VM0_BIT];
          end
        end
        pigc_pkg::ADDR_EL1: begin
          if (!HAS_EL3 && !HAS_EL2) begin
            state_nxt.id_gen_enable = wword[pigc_pkg::EL1_EN_BIT];
          end
          state_nxt.el1_pid = wword[pigc_pkg::EL1_PID_LSB +: PID_W];
          state_nxt.el1_grp = wword[pigc_pkg::EL1_GRP_LSB +: GRP_W];
        end
        default: state_nxt.el1_pid = state_r.el1_pid;
      endcase
    end

    // Tag each request from the settings current at issue
    state_nxt.rq_valid = req_valid_in;
    if (!state_r.id_gen_enable) begin
      state_nxt.rq_pid = '0;
      state_nxt.rq_grp = '0;
    end else if (req_secure_in && sdef_eff) begin
      state_nxt.rq_pid = space_eff ? PID_W'(pigc_pkg::DEF_NS_PID)
                                   : PID_W'(pigc_pkg::DEF_SECURE_PID);
      state_nxt.rq_grp = GRP_W'(pigc_pkg::DEF_GROUP);
    end else begin
      state_nxt.rq_pid = state_r.el1_pid;
      state_nxt.rq_grp = state_r.el1_grp;
    end
    state_nxt.rq_tag = !req_secure_in || space_eff || !SECURE_PIDS;

    state_nxt.ac_done = acc_valid_in;
    if (acc_valid_in) begin
      state_nxt.ac_result   = check_access(acc_el_in, acc_secure_in, acc_reg_in);
      state_nxt.last_result = state_nxt.ac_result;
    end

    if (reset_in) begin
      state_nxt.wait_q      = 1'b1;
      state_nxt.rdata       = 32'h0000_0000;
      state_nxt.id_gen_enable    = pigc_pkg::RST_ENABLE;
      state_nxt.lower_level_trap = pigc_pkg::RST_LOWER_TRAP;
      if (SPACE_PRESENT && SECURE_PIDS) begin
        state_nxt.secure_space_override = pigc_pkg::RST_SPACE_OVR;
      end
      if (!HAS_EL3) begin
        state_nxt.el1_register_trap     = pigc_pkg::RST_NOEL3_TRAPS;
        state_nxt.el0_register_trap     = pigc_pkg::RST_NOEL3_TRAPS;
        state_nxt.id_register_read_trap = pigc_pkg::RST_NOEL3_TRAPS;
      end
      state_nxt.rq_valid    = 1'b0;
      state_nxt.rq_pid      = '0;
      state_nxt.rq_grp      = '0;
      state_nxt.rq_tag      = 1'b0;
      state_nxt.ac_done     = 1'b0;
      state_nxt.ac_result   = pigc_pkg::ACC_UNDEF;
      state_nxt.last_result = pigc_pkg::ACC_ALLOW;
    end
  end

  // Fields left unreset keep whatever they held
  always_ff @(posedge clk_in) begin
    state_r <= state_nxt;
  end

  assign avs_readdata_out       = state_r.rdata;
  assign avs_waitrequest_out    = state_r.wait_q;
  assign req_valid_out          = state_r.rq_valid;
  assign partition_id_out       = state_r.rq_pid;
  assign monitor_group_out      = state_r.rq_grp;
  assign security_space_tag_out = state_r.rq_tag;
  assign acc_done_out           = state_r.ac_done;
  assign acc_result_out         = state_r.ac_result;

  // Checks
  a_enable_reset: assert property (@(posedge clk_in)
    $past(reset_in) |-> !state_r.id_gen_enable)
    else $error("enable not cleared by reset");

  a_trap_reset: assert property (@(posedge clk_in)
    $past(reset_in) |-> state_r.lower_level_trap)
    else $error("lower trap not set by reset");

  a_disabled_zero: assert property (@(posedge clk_in) disable iff (reset_in)
    req_valid_in && !state_r.id_gen_enable |=> partition_id_out == '0 && monitor_group_out == '0)
    else $error("disabled request carried nonzero ids");

  a_normal_ns: assert property (@(posedge clk_in) disable iff (reset_in)
    req_valid_in && !req_secure_in && state_r.id_gen_enable
    |=> req_valid_out && partition_id_out == $past(state_r.el1_pid))
    else $error("non-secure request not generated normally");

  a_ns_tag_one: assert property (@(posedge clk_in) disable iff (reset_in)
    req_valid_in && !req_secure_in |=> security_space_tag_out)
    else $error("non-secure tag not one");

  a_secure_tag: assert property (@(posedge clk_in) disable iff (reset_in)
    req_valid_in && req_secure_in && SPACE_PRESENT && SECURE_PIDS && HAS_EL3
    |=> security_space_tag_out == $past(state_r.secure_space_override))
    else $error("secure tag does not follow override");

  a_lower_trap: assert property (@(posedge clk_in) disable iff (reset_in)
    acc_valid_in && trap_low_eff && acc_el_in == 2'd2 && el2_active(acc_secure_in)
    && acc_reg_in == pigc_pkg::REG_EL2
    |=> acc_done_out && acc_result_out == pigc_pkg::ACC_TRAP_EL3)
    else $error("el2 access not trapped to el3");

  a_trap_priority: assert property (@(posedge clk_in) disable iff (reset_in)
    acc_valid_in && trap_low_eff && acc_el_in == 2'd1 && acc_reg_in == pigc_pkg::REG_EL1
    |=> acc_result_out == pigc_pkg::ACC_TRAP_EL3)
    else $error("lower trap lost priority");

  a_el3_allowed: assert property (@(posedge clk_in) disable iff (reset_in)
    acc_valid_in && acc_el_in == 2'd3 && acc_reg_in == pigc_pkg::REG_EL1
    |=> acc_result_out == pigc_pkg::ACC_ALLOW)
    else $error("el3 access refused");

  a_bus_answer: assert property (@(posedge clk_in) disable iff (reset_in)
    avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer not in one cycle");

  c_secure_default: cover property (@(posedge clk_in) disable iff (reset_in)
    req_valid_in && req_secure_in && sdef_eff && state_r.id_gen_enable);
  c_trap_el2: cover property (@(posedge clk_in) disable iff (reset_in)
    acc_done_out && acc_result_out == pigc_pkg::ACC_TRAP_EL2);
  c_memory: cover property (@(posedge clk_in) disable iff (reset_in)
    acc_done_out && acc_result_out == pigc_pkg::ACC_MEMORY);

endmodule

`default_nettype wire

// File: hdl/pigc_pkg.sv
// Package for the partition ID generation control block: map, fields, reset values, codes.
package pigc_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam logic [4:0] ADDR_EL3  = 5'h00;
  localparam logic [4:0] ADDR_EL2  = 5'h04;
  localparam logic [4:0] ADDR_HCR  = 5'h08;
  localparam logic [4:0] ADDR_EL1  = 5'h0c;
  localparam logic [4:0] ADDR_IDR  = 5'h10;
  localparam logic [4:0] ADDR_STAT = 5'h14;

  // el3_partition_control fields
  localparam int EL3_EN_BIT    = 0;
  localparam int EL3_SDEF_BIT  = 1;
  localparam int EL3_SPACE_BIT = 2;
  localparam int EL3_TRAP_BIT  = 3;

  // el2_partition_control fields
  localparam int EL2_EN_BIT    = 0;
  localparam int EL2_T1_BIT    = 1;
  localparam int EL2_T0_BIT    = 2;

  // hypervisor_partition_control fields
  localparam int HCR_IDT_BIT   = 0;
  localparam int HCR_LOCK_BIT  = 1;
  localparam int HCR_VM1_BIT   = 2;
  localparam int HCR_VM0_BIT   = 3;

  // el1_partition_control fields
  localparam int EL1_PID_LSB   = 0;
  localparam int EL1_GRP_LSB   = 16;
  localparam int EL1_EN_BIT    = 31;

  // partition_id_capabilities fields
  localparam int IDR_SDEF_BIT  = 0;
  localparam int IDR_SPACE_BIT = 1;
  localparam int IDR_EL3_BIT   = 2;
  localparam int IDR_EL2_BIT   = 3;
  localparam int IDR_SPID_BIT  = 4;

  // Values after reset
  localparam logic RST_ENABLE      = 1'b0;
  localparam logic RST_LOWER_TRAP  = 1'b1;
  localparam logic RST_SPACE_OVR   = 1'b0;
  localparam logic RST_NOEL3_TRAPS = 1'b1;

  // Default identifiers
  localparam logic [15:0] DEF_SECURE_PID = 16'h0000;
  localparam logic [15:0] DEF_NS_PID     = 16'h0000;
  localparam logic [7:0]  DEF_GROUP      = 8'h00;

  // Register selected by a system-register access check
  typedef enum logic [2:0] {
    REG_EL3   = 3'b000,
    REG_EL2   = 3'b001,
    REG_HCR   = 3'b010,
    REG_EL1   = 3'b011,
    REG_ALIAS = 3'b100,
    REG_IDR   = 3'b101,
    REG_VMAP  = 3'b110
  } pigc_reg_e;

  // Outcome of a system-register access check
  typedef enum logic [2:0] {
    ACC_ALLOW    = 3'b000,
    ACC_UNDEF    = 3'b001,
    ACC_TRAP_EL2 = 3'b010,
    ACC_TRAP_EL3 = 3'b011,
    ACC_MEMORY   = 3'b100
  } pigc_acc_e;

endpackage

// File: verification/partition_id_gen_control_test.sv
// Self-checking bench for the partition ID generation control block.
`timescale 1ns/1ns
`default_nettype none
module partition_id_gen_control_test;
  logic        clk_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0]  avs_byteenable_in;
  logic        sel2_in, nest_in, enh_nest_in, host_in, req_valid_in, req_secure_in, req_valid_out;
  logic [15:0] pid;
  logic [7:0]  grp, count;
  logic        tag, acc_valid_in, acc_secure_in, acc_done_out;
  logic [1:0]  acc_el_in;
  logic [2:0]  acc_reg_in, acc_result_out;
  logic [24:0] last;
  int          num_errors, comparisons;
  localparam logic [24:0] SEC_DEF = {1'b0, pigc_pkg::DEF_GROUP, pigc_pkg::DEF_SECURE_PID};
  localparam logic [24:0] NS_DEF  = {1'b1, pigc_pkg::DEF_GROUP, pigc_pkg::DEF_NS_PID};

  pigc_partition_ctrl i_dut (.clk_in(clk_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .secure_el2_enable_in(sel2_in), .nested_virt_in(nest_in), .enh_nested_virt_in(enh_nest_in),
    .host_mode_in(host_in), .req_valid_in(req_valid_in), .req_secure_in(req_secure_in),
    .req_valid_out(req_valid_out), .partition_id_out(pid), .monitor_group_out(grp),
    .security_space_tag_out(tag), .acc_valid_in(acc_valid_in), .acc_el_in(acc_el_in),
    .acc_secure_in(acc_secure_in), .acc_reg_in(acc_reg_in), .acc_done_out(acc_done_out),
    .acc_result_out(acc_result_out));
  pigc_mem_sink i_sink (.clk_in(clk_in), .reset_in(reset_in), .valid_in(req_valid_out),
    .pid_in(pid), .grp_in(grp), .tag_in(tag), .last_out(last), .count_out(count));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic results();
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n = 0;
    @(posedge clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= w;
    avs_read_in      <= !w;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      results();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, exp);
  endtask

  // One request; the tagged result must reach the sink exactly once
  task automatic req(input logic sec, input logic [24:0] exp);
    logic [7:0] c0;
    c0 = count;
    @(posedge clk_in);
    req_valid_in  <= 1'b1;
    req_secure_in <= sec;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check({7'h00, last}, {7'h00, exp});
    check({24'h0, count}, {24'h0, c0 + 8'h01});
  endtask

  task automatic acc(input logic [1:0] el, input logic [2:0] r, input pigc_pkg::pigc_acc_e e);
    @(posedge clk_in);
    acc_valid_in <= 1'b1;
    acc_el_in    <= el;
    acc_reg_in   <= r;
    @(posedge clk_in);
    acc_valid_in <= 1'b0;
    @(posedge clk_in);
    check({31'h0, acc_done_out}, 32'h1);
    check({29'h0, acc_result_out}, {29'h0, e});
  endtask

  initial begin
    num_errors = 0;
    comparisons = 0;
    reset_in = 1'b1;
    {avs_read_in, avs_write_in, req_valid_in, req_secure_in, acc_valid_in} = 5'h00;
    {nest_in, enh_nest_in, host_in, acc_secure_in} = 4'h0;
    sel2_in = 1'b1;
    avs_address_in = 5'h00;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'hf;
    acc_el_in = 2'h0;
    acc_reg_in = 3'h0;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(pigc_pkg::ADDR_EL3, 32'h8, 32'hd);
    rd(pigc_pkg::ADDR_EL2, 32'h0, 32'h1);
    rd(pigc_pkg::ADDR_IDR, 32'h1f, 32'h1f);
    rd(5'h18, 32'h0, 32'hffffffff);
    acc(2'd1, pigc_pkg::REG_EL1, pigc_pkg::ACC_TRAP_EL3);
    acc(2'd3, pigc_pkg::REG_EL1, pigc_pkg::ACC_ALLOW);
    nest_in <= 1'b1;
    acc(2'd2, pigc_pkg::REG_EL2, pigc_pkg::ACC_TRAP_EL3);
    wr(pigc_pkg::ADDR_EL2, 32'h2);
    acc(2'd1, pigc_pkg::REG_EL1, pigc_pkg::ACC_TRAP_EL3);
    enh_nest_in <= 1'b1;
    acc(2'd1, pigc_pkg::REG_ALIAS, pigc_pkg::ACC_MEMORY);
    nest_in     <= 1'b0;
    enh_nest_in <= 1'b0;
    wr(pigc_pkg::ADDR_EL3, 32'h0);
    acc(2'd1, pigc_pkg::REG_EL1, pigc_pkg::ACC_TRAP_EL2);
    acc(2'd0, pigc_pkg::REG_EL1, pigc_pkg::ACC_UNDEF);
    acc(2'd2, pigc_pkg::REG_ALIAS, pigc_pkg::ACC_UNDEF);
    host_in <= 1'b1;
    acc(2'd2, pigc_pkg::REG_ALIAS, pigc_pkg::ACC_ALLOW);
    host_in <= 1'b0;
    wr(pigc_pkg::ADDR_HCR, 32'h1);
    rd(pigc_pkg::ADDR_HCR, 32'h1, 32'hf);
    acc(2'd1, pigc_pkg::REG_IDR, pigc_pkg::ACC_TRAP_EL2);
    acc_secure_in <= 1'b1;
    sel2_in <= 1'b0;
    acc(2'd1, pigc_pkg::REG_EL1, pigc_pkg::ACC_ALLOW);
    acc(2'd1, pigc_pkg::REG_IDR, pigc_pkg::ACC_ALLOW);
    acc(2'd2, pigc_pkg::REG_EL2, pigc_pkg::ACC_UNDEF);
    req(1'b1, SEC_DEF);
    req(1'b0, NS_DEF);
    wr(pigc_pkg::ADDR_EL3, 32'h1);
    wr(pigc_pkg::ADDR_EL1, 32'h0056_1234);
    rd(pigc_pkg::ADDR_EL1, 32'h8056_1234, 32'hffffffff);
    rd(pigc_pkg::ADDR_EL2, 32'h1, 32'h1);
    req(1'b1, {1'b0, 8'h56, 16'h1234});
    req(1'b0, {1'b1, 8'h56, 16'h1234});
    wr(pigc_pkg::ADDR_EL3, 32'h3);
    rd(pigc_pkg::ADDR_EL3, 32'h3, 32'hf);
    req(1'b1, SEC_DEF);
    req(1'b0, {1'b1, 8'h56, 16'h1234});
    wr(pigc_pkg::ADDR_EL3, 32'h7);
    req(1'b1, {1'b1, pigc_pkg::DEF_GROUP, pigc_pkg::DEF_NS_PID});
    @(posedge clk_in);
    reset_in <= 1'b1;
    @(posedge clk_in);
    reset_in <= 1'b0;
    rd(pigc_pkg::ADDR_EL3, 32'h8, 32'hd);
    results();
  end
endmodule
`default_nettype wire

// File: verification/pigc_mem_sink.sv
// Memory-system sink model that latches every tagged request leaving the block.
`timescale 1ns/1ns
`default_nettype none
module pigc_mem_sink (
  input  wire logic        clk_in,    // Clock
  input  wire logic        reset_in,  // Clears the record
  input  wire logic        valid_in,  // Tagged request valid
  input  wire logic [15:0] pid_in,    // partition_id
  input  wire logic [7:0]  grp_in,    // monitor_group
  input  wire logic        tag_in,    // security_space_tag
  output logic      [24:0] last_out,  // Tag, group and ID of last request
  output logic      [7:0]  count_out  // Requests accepted
);
  // Accepts one request per valid cycle and never stalls
  always @(posedge clk_in) begin
    if (reset_in) begin
      last_out  <= 25'h0000000;
      count_out <= 8'h00;
    end else if (valid_in === 1'b1) begin
      last_out  <= {tag_in, grp_in, pid_in};
      count_out <= count_out + 8'h01;
    end
  end
endmodule
`default_nettype wire
